/* File: bbs_sequencer.sv */
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module bbs_sequencer #(
    parameter int TICK_CYCLES = bbs_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // Avalon-MM slave
    input  wire logic [17:0] ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [3:0]  BYTEENABLE,
    output logic      [31:0] READDATA,
    output logic             WAITREQUEST,
    // Failure indication pin, active low
    input  wire logic        SELECTED_GENERAL_PIN_N,
    // Events from the function's USB logic, and the string grant back to it
    input  wire logic        ADDR_SET,
    input  wire logic        ALT_STRING_REQ,
    output logic             ALT_STRING_GRANT,
    // Function attach and identity
    output logic             FUNC_ATTACH,
    output logic             BILLBOARD_SEL,
    output logic      [1:0]  CONFIG_STATUS
);
    import bbs_pkg::*;

    typedef struct packed {
        logic        fail_s1;
        logic        fail_s2;
        logic        armed;
        bbs_st_t     st;
        logic [1:0]  hold;
        logic [19:0] pre;
        logic [7:0]  a_lo;
        logic [7:0]  a_hi;
        logic [7:0]  b_lo;
        logic [7:0]  b_hi;
        logic [7:0]  ctrl;
        logic        ack;
        logic [31:0] rdata;
        logic        attach;
        logic        bb_sel;
        logic [1:0]  cfg;
    } bbs_state_t;

    bbs_state_t s_reg;
    bbs_state_t s_next;

    logic [15:0] idx;
    logic        req;
    logic        tick;
    logic        enable;
    logic        fail_seen;
    logic        in_bb;
    logic        a_start;
    logic        b_start;
    logic        tmr_clear;
    logic        a_run;
    logic        b_run;
    logic        a_exp;
    logic        b_exp;
    logic [7:0]  status;
    logic [7:0]  rd_byte;

    assign idx       = ADDRESS[17:2];
    assign req       = READ || WRITE;
    assign tick      = (s_reg.pre == 20'(TICK_CYCLES - 1));
    assign enable    = s_reg.ctrl[CTRL_EN_BIT];
    // Needs a high level seen first, so a held-low pin cannot loop
    assign fail_seen = enable && s_reg.armed && !s_reg.fail_s2;
    assign in_bb     = (s_reg.st == ST_BB_ON);

    assign a_start   = in_bb && ADDR_SET;
    assign b_start   = in_bb && ALT_STRING_REQ;
    assign tmr_clear = !in_bb;
    assign ALT_STRING_GRANT = in_bb && ALT_STRING_REQ;

    // Answer comes one cycle after the request appears
    assign WAITREQUEST = req && !s_reg.ack;
    assign READDATA    = s_reg.rdata;
    assign FUNC_ATTACH   = s_reg.attach;
    assign BILLBOARD_SEL = s_reg.bb_sel;
    assign CONFIG_STATUS = s_reg.cfg;

    bbs_timer u_timer_a (
        .CLOCK   (CLOCK),
        .RESET   (RESET),
        .START   (a_start),
        .CLEAR   (tmr_clear),
        .TICK    (tick),
        .LIMIT   ({s_reg.a_hi, s_reg.a_lo}),
        .RUNNING (a_run),
        .EXPIRE  (a_exp)
    );

    bbs_timer u_timer_b (
        .CLOCK   (CLOCK),
        .RESET   (RESET),
        .START   (b_start),
        .CLEAR   (tmr_clear),
        .TICK    (tick),
        .LIMIT   ({s_reg.b_hi, s_reg.b_lo}),
        .RUNNING (b_run),
        .EXPIRE  (b_exp)
    );

    always_comb begin
        status = 8'h00;
        status[STAT_ATT_BIT] = s_reg.attach;
        status[STAT_BB_BIT]  = s_reg.bb_sel;
        status[STAT_A_BIT]   = a_run;
        status[STAT_B_BIT]   = b_run;
        status[STAT_IN_BIT]  = s_reg.fail_s2;
        status[STAT_ARM_BIT] = s_reg.armed;
    end

    always_comb begin
        case (idx)
            REG_A_LO_IDX: rd_byte = s_reg.a_lo;
            REG_A_HI_IDX: rd_byte = s_reg.a_hi;
            REG_B_LO_IDX: rd_byte = s_reg.b_lo;
            REG_B_HI_IDX: rd_byte = s_reg.b_hi;
            REG_CTRL_IDX: rd_byte = s_reg.ctrl;
            REG_STAT_IDX: rd_byte = status;
            default:      rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        s_next.fail_s1 = SELECTED_GENERAL_PIN_N;
        s_next.fail_s2 = s_reg.fail_s1;
        s_next.pre = tick ? 20'h00000 : s_reg.pre + 20'h00001;
        s_next.cfg = CFG_UNSPEC;

        // Register access
        s_next.ack = req && !s_reg.ack;
        if (req && !s_reg.ack && READ) begin
            s_next.rdata = {24'h000000, rd_byte};
        end
        if (WRITE && s_reg.ack && BYTEENABLE[0]) begin
            case (idx)
                REG_A_LO_IDX: s_next.a_lo = WRITEDATA[7:0];
                REG_A_HI_IDX: s_next.a_hi = WRITEDATA[7:0];
                REG_B_LO_IDX: s_next.b_lo = WRITEDATA[7:0];
                REG_B_HI_IDX: s_next.b_hi = WRITEDATA[7:0];
                REG_CTRL_IDX: s_next.ctrl = WRITEDATA[7:0] & CTRL_MASK;
                default:      s_next.ctrl = s_reg.ctrl;
            endcase
        end

        if (s_reg.fail_s2) begin
            s_next.armed = 1'b1;
        end

        case (s_reg.st)
            ST_NORMAL: begin
                if (fail_seen) begin
                    s_next.st     = ST_DETACH_BB;
                    s_next.attach = 1'b0;
                    s_next.armed  = 1'b0;
                    s_next.hold   = 2'd0;
                end
            end
            ST_DETACH_BB: begin
                if (tick) begin
                    s_next.hold = s_reg.hold + 2'd1;
                end
                if (tick && (s_reg.hold + 2'd1 >= DETACH_TICKS)) begin
                    s_next.st     = ST_BB_ON;
                    s_next.bb_sel = 1'b1;
                    s_next.attach = 1'b1;
                end
            end
            ST_BB_ON: begin
                if (a_exp || b_exp) begin
                    s_next.st     = ST_DETACH_NORM;
                    s_next.attach = 1'b0;
                    s_next.hold   = 2'd0;
                end
            end
            ST_DETACH_NORM: begin
                if (tick) begin
                    s_next.hold = s_reg.hold + 2'd1;
                end
                if (tick && (s_reg.hold + 2'd1 >= DETACH_TICKS)) begin
                    s_next.st     = ST_NORMAL;
                    s_next.bb_sel = 1'b0;
                    s_next.attach = 1'b1;
                end
            end
            default: begin
                s_next.st     = ST_NORMAL;
                s_next.bb_sel = 1'b0;
                s_next.attach = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            s_reg.fail_s1 <= 1'b1;
            s_reg.fail_s2 <= 1'b1;
            s_reg.armed   <= 1'b1;
            s_reg.st      <= ST_NORMAL;
            s_reg.hold    <= 2'd0;
            s_reg.pre     <= 20'h00000;
            s_reg.a_lo    <= A_LO_RESET;
            s_reg.a_hi    <= A_HI_RESET;
            s_reg.b_lo    <= B_LO_RESET;
            s_reg.b_hi    <= B_HI_RESET;
            s_reg.ctrl    <= CTRL_RESET;
            s_reg.ack     <= 1'b0;
            s_reg.rdata   <= 32'h00000000;
            s_reg.attach  <= 1'b1;
            s_reg.bb_sel  <= 1'b0;
            s_reg.cfg     <= CFG_UNSPEC;
        end else begin
            s_reg <= s_next;
        end
    end

    AST_FAIL_DETACH: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (s_reg.st == ST_NORMAL && fail_seen)
        |=> (!FUNC_ATTACH && s_reg.st == ST_DETACH_BB)
    ) else $error("failure input did not force a detach");

    AST_BB_REATTACH: assert property (
        @(posedge CLOCK) disable iff (RESET)
        ($rose(FUNC_ATTACH) && $past(s_reg.st) == ST_DETACH_BB)
        |-> (BILLBOARD_SEL && s_reg.st == ST_BB_ON)
    ) else $error("reattach after failure lacks billboard identity");

    AST_A_START: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (in_bb && ADDR_SET && !a_exp && !b_exp)
        |=> (a_run && !$past(tick && a_exp))
    ) else $error("address set did not start timer A");

    AST_LIMIT_RESET: assert property (
        @(posedge CLOCK)
        $fell(RESET)
        |-> ({s_reg.a_hi, s_reg.a_lo} == 16'd2000
             && {s_reg.b_hi, s_reg.b_lo} == 16'd2000)
    ) else $error("timer limits not twenty seconds after reset");

    AST_CFG_UNSPEC: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (BILLBOARD_SEL && FUNC_ATTACH) |-> (CONFIG_STATUS == 2'b00)
    ) else $error("configuration status not unspecified error");

    AST_B_START: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (in_bb && ALT_STRING_REQ && !a_exp && !b_exp)
        |-> ALT_STRING_GRANT ##1 b_run
    ) else $error("string request not answered or timer B idle");

    AST_EXPIRE_DETACH: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (in_bb && (a_exp || b_exp))
        |=> (!FUNC_ATTACH && s_reg.st == ST_DETACH_NORM)
    ) else $error("timer expiry did not force a detach");

    AST_NORMAL_RETURN: assert property (
        @(posedge CLOCK) disable iff (RESET)
        ($rose(FUNC_ATTACH) && $past(s_reg.st) == ST_DETACH_NORM)
        |-> (!BILLBOARD_SEL && s_reg.st == ST_NORMAL)
    ) else $error("reattach after expiry kept billboard identity");

    AST_WRITE_A: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && idx == REG_A_LO_IDX)
        |=> (s_reg.a_lo == $past(WRITEDATA[7:0]))
    ) else $error("timer A low byte write lost");

    AST_WRITE_B: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (WRITE && !WAITREQUEST && BYTEENABLE[0] && idx == REG_B_HI_IDX)
        |=> (s_reg.b_hi == $past(WRITEDATA[7:0]))
    ) else $error("timer B high byte write lost");

    AST_DISABLED: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (s_reg.st == ST_NORMAL && !enable) |=> (s_reg.st == ST_NORMAL)
    ) else $error("sequence left normal while disabled");

    AST_TIMERS_IDLE: assert property (
        @(posedge CLOCK) disable iff (RESET)
        (s_reg.st != ST_BB_ON) |=> (!a_run && !b_run) or (s_reg.st == ST_BB_ON)
    ) else $error("timer running outside billboard phase");
endmodule
`default_nettype wire

/* File: bbs_pkg.sv */
`default_nettype none
package bbs_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_DETACH_BB,
        ST_BB_ON,
        ST_DETACH_NORM
    } bbs_st_t;

    // Register indices; byte address is four times the index
    localparam logic [15:0] REG_A_LO_IDX = 16'h413c;
    localparam logic [15:0] REG_A_HI_IDX = 16'h413d;
    localparam logic [15:0] REG_B_LO_IDX = 16'h413e;
    localparam logic [15:0] REG_B_HI_IDX = 16'h413f;
    localparam logic [15:0] REG_CTRL_IDX = 16'h4140;
    localparam logic [15:0] REG_STAT_IDX = 16'h4141;

    // Reset values and control write mask
    localparam logic [7:0]  A_LO_RESET   = 8'hd0;
    localparam logic [7:0]  A_HI_RESET   = 8'h07;
    localparam logic [7:0]  B_LO_RESET   = 8'hd0;
    localparam logic [7:0]  B_HI_RESET   = 8'h07;
    localparam logic [7:0]  CTRL_RESET   = 8'h14;
    localparam logic [7:0]  CTRL_MASK    = 8'h3f;

    // Field positions
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          STAT_ATT_BIT = 0;
    localparam int          STAT_BB_BIT  = 1;
    localparam int          STAT_A_BIT   = 2;
    localparam int          STAT_B_BIT   = 3;
    localparam int          STAT_IN_BIT  = 4;
    localparam int          STAT_ARM_BIT = 5;

    // Configuration status field: unspecified error
    localparam logic [1:0]  CFG_UNSPEC   = 2'b00;

    // Timing: 10 ms timer unit at a 10 ns clock
    localparam int          TICK_NS      = 10000000;
    localparam int          CLK_NS       = 10;
    localparam int          TICK_CYCLES  = TICK_NS / CLK_NS;
    localparam logic [1:0]  DETACH_TICKS = 2'd2;
endpackage
`default_nettype wire

/* File: bbs_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module bbs_timer (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // Control
    input  wire logic        START,
    input  wire logic        CLEAR,
    input  wire logic        TICK,
    input  wire logic [15:0] LIMIT,
    // Status
    output logic             RUNNING,
    output logic             EXPIRE
);
    import bbs_pkg::*;

    typedef struct packed {
        logic        run;
        logic [15:0] cnt;
    } bbs_tmr_t;

    bbs_tmr_t s_reg;
    bbs_tmr_t s_next;
    logic [16:0] elapsed;

    assign elapsed = {1'b0, s_reg.cnt} + 17'd1;
    // Limit of zero expires on the first tick
    assign EXPIRE  = s_reg.run && TICK && !CLEAR && !START
                     && (elapsed >= {1'b0, LIMIT});
    assign RUNNING = s_reg.run;

    always_comb begin
        s_next = s_reg;
        if (CLEAR) begin
            s_next.run = 1'b0;
            s_next.cnt = 16'h0000;
        end else if (START) begin
            s_next.run = 1'b1;
            s_next.cnt = 16'h0000;
        end else if (EXPIRE) begin
            s_next.run = 1'b0;
            s_next.cnt = 16'h0000;
        end else if (s_reg.run && TICK) begin
            s_next.cnt = elapsed[15:0];
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule
`default_nettype wire

/* File: bbs_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bbs_far_model (
    // Clock
    input  wire logic       CLOCK,
    // Commands from the bench
    input  wire logic       FAIL_REQ,
    input  wire logic       STRAY,
    input  wire logic [7:0] ADDR_DLY,
    input  wire logic [7:0] STR_DLY,
    // Device outputs seen by the host
    input  wire logic       FUNC_ATTACH,
    input  wire logic       BILLBOARD_SEL,
    // Towards the device
    output logic            SELECTED_GENERAL_PIN_N,
    output logic            ADDR_SET,
    output logic            ALT_STRING_REQ
);
    logic attach_q;
    int   cnt;

    initial begin
        SELECTED_GENERAL_PIN_N = 1'b1;
        ADDR_SET = 1'b0;
        ALT_STRING_REQ = 1'b0;
        attach_q = 1'b1;
        cnt = -1;
    end

    // Host enumerates only a freshly attached billboard function
    always @(posedge CLOCK) begin
        SELECTED_GENERAL_PIN_N <= !FAIL_REQ;
        attach_q <= FUNC_ATTACH;
        // One assignment per pulse signal and edge
        ADDR_SET <= STRAY || (cnt == int'(ADDR_DLY));
        ALT_STRING_REQ <= STRAY
                          || (STR_DLY != 8'h00 && cnt == int'(ADDR_DLY) + int'(STR_DLY));
        if (FUNC_ATTACH && !attach_q && BILLBOARD_SEL)
            cnt <= 0;
        else if (!FUNC_ATTACH)
            cnt <= -1;
        else if (cnt >= 0)
            cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb;
    import bbs_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [17:0] address = '0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0]  byteenable = '0;
    logic [31:0] readdata;
    logic        waitrequest, pin_n, addr_set, alt_req, alt_grant, func_attach, bb_sel;
    logic [1:0]  cfg_status;
    logic        fail_req = 1'b0;
    logic        stray = 1'b0;
    logic [7:0]  addr_dly = 8'h05;
    logic [7:0]  str_dly = 8'h00;
    logic [7:0]  rd;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n;

    always #5 clock = ~clock;

    bbs_sequencer #(.TICK_CYCLES(10)) dut (
        .CLOCK(clock), .RESET(reset), .ADDRESS(address), .READ(read), .WRITE(write),
        .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
        .WAITREQUEST(waitrequest), .SELECTED_GENERAL_PIN_N(pin_n), .ADDR_SET(addr_set),
        .ALT_STRING_REQ(alt_req), .ALT_STRING_GRANT(alt_grant), .FUNC_ATTACH(func_attach),
        .BILLBOARD_SEL(bb_sel), .CONFIG_STATUS(cfg_status));

    bbs_far_model far (
        .CLOCK(clock), .FAIL_REQ(fail_req), .STRAY(stray), .ADDR_DLY(addr_dly),
        .STR_DLY(str_dly), .FUNC_ATTACH(func_attach), .BILLBOARD_SEL(bb_sel),
        .SELECTED_GENERAL_PIN_N(pin_n), .ADDR_SET(addr_set), .ALT_STRING_REQ(alt_req));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [7:0] q);
        @(posedge clock);
        address <= {idx, 2'b00};
        writedata <= {24'h0, wd};
        byteenable <= be;
        read <= !wr;
        write <= wr;
        // Only waitrequest low or the global cycle limit ends this wait
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wait_attach(input logic lvl, input int lim, output int c);
        c = 0;
        while (func_attach !== lvl && c < lim) begin
            @(negedge clock);
            c++;
        end
    endtask

    task automatic regs_reset();
        logic [15:0] idx [6] = '{REG_A_LO_IDX, REG_A_HI_IDX, REG_B_LO_IDX, REG_B_HI_IDX,
                                 REG_CTRL_IDX, 16'h4150};
        logic [7:0]  exp [6] = '{8'hd0, 8'h07, 8'hd0, 8'h07, 8'h14, 8'h00};
        `CHK("attach after reset", 1'b1, func_attach)
        `CHK("identity after reset", 1'b0, bb_sel)
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, idx[i], 8'h00, 4'hf, rd);
            `CHK("reset value", exp[i], rd)
        end
    endtask

    task automatic regs_rw();
        logic [15:0] idx [4] = '{REG_A_LO_IDX, REG_A_HI_IDX, REG_B_LO_IDX, REG_B_HI_IDX};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, idx[i], 8'h5a ^ 8'(i), 4'h1, rd);
            bus(1'b0, idx[i], 8'h00, 4'hf, rd);
            `CHK("timer byte", 8'h5a ^ 8'(i), rd)
        end
        bus(1'b1, REG_A_HI_IDX, 8'h33, 4'he, rd);
        bus(1'b0, REG_A_HI_IDX, 8'h00, 4'hf, rd);
        `CHK("write without lane", 8'h5b, rd)
        bus(1'b1, 16'h4150, 8'h77, 4'hf, rd);
        bus(1'b0, 16'h4150, 8'h00, 4'hf, rd);
        `CHK("unmapped", 8'h00, rd)
        bus(1'b1, REG_CTRL_IDX, 8'hfe, 4'h1, rd);
        bus(1'b0, REG_CTRL_IDX, 8'h00, 4'hf, rd);
        `CHK("control mask", 8'h3e, rd)
    endtask

    task automatic disabled_and_stray();
        @(posedge clock);
        fail_req <= 1'b1;
        wait_attach(1'b0, 40, n);
        `CHK("attach while disabled", 40, n)
        @(posedge clock);
        fail_req <= 1'b0;
        stray <= 1'b1;
        @(posedge clock);
        stray <= 1'b0;
        @(negedge clock);
        `CHK("grant in normal state", 1'b0, alt_grant)
        bus(1'b1, REG_CTRL_IDX, 8'h15, 4'h1, rd);
    endtask

    // Runs a full failure sequence; limit in ticks of the timer that should end it
    task automatic sequence_run(input logic use_str, input int lim);
        @(posedge clock);
        addr_dly <= use_str ? 8'h02 : 8'h09;
        str_dly <= use_str ? 8'h04 : 8'h00;
        fail_req <= 1'b1;
        wait_attach(1'b0, 10, n);
        `CHK("detach on failure", 1'b1, n >= 3 && n <= 7)
        wait_attach(1'b1, 30, n);
        `CHK("detach length", 1'b1, n >= 9 && n <= 21)
        `CHK("billboard identity", 1'b1, bb_sel)
        `CHK("config status", CFG_UNSPEC, cfg_status)
        n = 0;
        while ((use_str ? alt_req : addr_set) !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        `CHK("host event", 1'b1, use_str ? alt_req : addr_set)
        if (use_str)
            `CHK("string grant", 1'b1, alt_grant)
        // Start falls between ticks, so the first tick is partial
        wait_attach(1'b0, 60, n);
        `CHK("expiry", 1'b1, n >= lim * 10 - 8 && n <= lim * 10 + 1)
        wait_attach(1'b1, 30, n);
        `CHK("normal identity", 1'b0, bb_sel)
        wait_attach(1'b0, 40, n);
        `CHK("no retrigger while low", 40, n)
        bus(1'b0, REG_STAT_IDX, 8'h00, 4'hf, rd);
        `CHK("timers idle", 2'b00, rd[STAT_B_BIT:STAT_A_BIT])
        `CHK("status byte", 8'h01, rd)
        @(posedge clock);
        fail_req <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        regs_reset();
        regs_rw();
        bus(1'b1, REG_CTRL_IDX, 8'h14, 4'h1, rd);
        disabled_and_stray();
        bus(1'b1, REG_A_LO_IDX, 8'h03, 4'h1, rd);
        bus(1'b1, REG_A_HI_IDX, 8'h00, 4'h1, rd);
        bus(1'b1, REG_B_LO_IDX, 8'hff, 4'h1, rd);
        bus(1'b1, REG_B_HI_IDX, 8'h00, 4'h1, rd);
        sequence_run(1'b0, 3);
        bus(1'b1, REG_A_LO_IDX, 8'hff, 4'h1, rd);
        bus(1'b1, REG_B_LO_IDX, 8'h02, 4'h1, rd);
        sequence_run(1'b1, 2);
        give_verdict();
    end
endmodule
`default_nettype wire
